// [chg_map.svh]
// Purpose: offsets, field positions, reset values and timing counts for changeover control
// Assumes: 100 MHz clock, byte addressed AXI4-Lite with 32-bit words
// Notes: definitions only
`ifndef CHG_MAP_SVH
`define CHG_MAP_SVH
`define CLK_HZ 100000000
`define TICK_CYCLES (`CLK_HZ)
`define FAST_FAIL_S 2
`define SLOW_FAIL_S 10
`define RECOVER_S 2
`define SETTLE_S 30
`define HOUR_S 3600
`define CHG_MAX 3'h4
`define CTRL_OFS 4'h0
`define STAT_OFS 4'h4
`define CMD_OFS 4'h8
`define CTRL_RESET 32'h00000000
`define CTRL_AUTO_MUTE 0
`define CTRL_AUTO_LOW 1
`define CMD_PREF_A 0
`define CMD_PREF_B 1
`define CMD_TOGGLE 2
`define CMD_CLEAR 3
`define CMD_REMOTE 4
`endif

// [chg_pkg.sv]
// Purpose: shared types for changeover control
// Assumes: nothing
// Notes: constants live in chg_map.svh
package chg_pkg;
    typedef enum logic [1:0] {SEL_AUTO, SEL_A, SEL_B} sel_sw_t;
    typedef enum logic [1:0] {MSW_AUTO, MSW_MUTE, MSW_START} mute_sw_t;
    typedef enum logic [1:0] {ST_SETTLE, ST_WATCH, ST_BLOCKED} chg_state_t;
endpackage

// [drive_health.sv]
// Purpose: per-drive persistence timers for fail and recovery
// Assumes: sec_tick one cycle per second, ce freezes all state
// Notes: instantiated once per drive
`timescale 1ns/1ps
`include "chg_map.svh"
module drive_health (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic sec_tick,
    input wire logic fast_bad,
    input wire logic slow_bad,
    output logic failed
);
    logic [3:0] fast_cnt_r;
    logic [3:0] slow_cnt_r;
    logic [3:0] good_cnt_r;
    logic failed_r;
    wire fast_hit = fast_cnt_r >= 4'(`FAST_FAIL_S);
    wire slow_hit = slow_cnt_r >= 4'(`SLOW_FAIL_S);
    wire good_hit = good_cnt_r >= 4'(`RECOVER_S);
    assign failed = failed_r;
    // Counters restart on any break in the condition, so only continuous runs count
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            fast_cnt_r <= 4'h0;
            slow_cnt_r <= 4'h0;
            good_cnt_r <= 4'h0;
            failed_r <= 1'b0;
        end
        else if (ce)
        begin
            if (!fast_bad) fast_cnt_r <= 4'h0;
            else if (sec_tick && !fast_hit) fast_cnt_r <= fast_cnt_r + 4'h1;
            if (!slow_bad) slow_cnt_r <= 4'h0;
            else if (sec_tick && !slow_hit) slow_cnt_r <= slow_cnt_r + 4'h1;
            if (fast_bad || slow_bad) good_cnt_r <= 4'h0;
            else if (sec_tick && !good_hit) good_cnt_r <= good_cnt_r + 4'h1;
            if (fast_hit || slow_hit) failed_r <= 1'b1; // RULE7
            else if (good_hit) failed_r <= 1'b0; // RULE10
        end
    end
endmodule

// [changeover_ctrl.sv]
// Purpose: automatic drive changeover and mute/power priority resolution
// Assumes: one clock at 100 MHz, synchronous active-low reset, AXI4-Lite registers
// Notes: interlock loop input is high when the loop is intact
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "chg_map.svh"
// Functional notes
// RULE1 - Automatic changeover only in selector auto; manual positions force that drive.
// RULE2 - Automatic mute and power settings apply only with mute switch in auto.
// RULE3 - Standby drive toggles passive/active; its health reads unknown while passive.
// RULE4 - Preferred drive A or B accepted from keys, rear inputs or remote always.
// RULE5 - Count automatic changeovers zero to four, reported in auto selection.
// RULE6 - Any drive preference clears counter and inhibits changeover about 30 seconds.
// RULE7 - Drive fails after fast fail 2 s or slow fail 10 s continuously.
// RULE8 - Passive standby always taken; active standby taken only when not failed.
// RULE9 - Each changeover increments counter and starts a fresh 30 second settle.
// RULE10 - Recovered after 2 s all good; never reselected unless current drive fails.
// RULE11 - After four changeovers block until cleared by hour timeout or intervention.
// RULE12 - Changing auto mute or power settings clears counter and settles 30 s.
// RULE13 - Manual mute switch position obeyed, overridden only by open interlock.
// RULE14 - Manual mode power level comes only from the internal link.
// RULE15 - Auto mute priority: interlock, then external mute, then internal setting.
// RULE16 - Under interlock or external mute, local mute keys ignored, remote accepted.
// RULE17 - Auto mode external low-power input beats internal power setting.
// RULE18 - Under external low power, local power keys ignored, remote accepted.
// RULE19 - Low power chosen remotely or by keys only with mute switch in auto.
// RULE20 - Internal link low power overrides every automatic power setting.
// RULE21 - Open interlock loop counts as active interlock.
// RULE22 - All intervals derive from one seconds tick made from the clock.
module changeover_ctrl #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire chg_pkg::sel_sw_t sel_sw,
    input wire chg_pkg::mute_sw_t mute_sw,
    input wire logic key_pref_a,
    input wire logic key_pref_b,
    input wire logic key_toggle,
    input wire logic key_mute,
    input wire logic key_start,
    input wire logic key_high,
    input wire logic key_low,
    input wire logic rear_pref_a,
    input wire logic rear_pref_b,
    input wire logic ext_mute,
    input wire logic ext_low,
    input wire logic interlock_loop,
    input wire logic link_low,
    input wire logic a_fast_bad,
    input wire logic a_slow_bad,
    input wire logic b_fast_bad,
    input wire logic b_slow_bad,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic drive_b_sel,
    output logic standby_active,
    output logic tx_mute,
    output logic tx_low
);
    // Seconds tick
    logic [26:0] div_r;
    logic sec_tick;
    wire div_end = div_r == 27'(TICK_CYCLES - 1);
    always_ff @(posedge clk)
    begin
        if (!resetn) div_r <= 27'h0000000;
        else if (ce) div_r <= div_end ? 27'h0000000 : div_r + 27'h0000001; // RULE22
    end
    assign sec_tick = div_end;

    // Drive health
    logic a_failed;
    logic b_failed;
    drive_health u_health_a (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .sec_tick(sec_tick),
        .fast_bad(a_fast_bad),
        .slow_bad(a_slow_bad),
        .failed(a_failed)
    );
    drive_health u_health_b (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .sec_tick(sec_tick),
        .fast_bad(b_fast_bad),
        .slow_bad(b_slow_bad),
        .failed(b_failed)
    );

    // Register bus: single-beat slave, address and data taken together
    logic [31:0] ctrl_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    wire rd_go = s_axi_arvalid && !rvalid_r;
    wire wr_ctrl = wr_go && s_axi_awaddr == `CTRL_OFS && s_axi_wstrb[0];
    wire wr_cmd = wr_go && s_axi_awaddr == `CMD_OFS && s_axi_wstrb[0];
    wire wr_ok = s_axi_awaddr == `CTRL_OFS || s_axi_awaddr == `CMD_OFS;
    assign s_axi_awready = ce && wr_go;
    assign s_axi_wready = ce && wr_go;
    assign s_axi_arready = ce && rd_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Remote command pulses
    wire rem_a = wr_cmd && s_axi_wdata[`CMD_PREF_A];
    wire rem_b = wr_cmd && s_axi_wdata[`CMD_PREF_B];
    wire rem_tog = wr_cmd && s_axi_wdata[`CMD_TOGGLE];
    wire rem_clr = wr_cmd && s_axi_wdata[`CMD_CLEAR];

    // Mute and power resolution
    wire ilock = !interlock_loop; // RULE21
    wire auto_mute_sw = mute_sw == chg_pkg::MSW_AUTO;
    wire mute_ovr = ilock || ext_mute;
    logic auto_mute_r;
    logic auto_low_r;
    // Local keys yield while an override holds; remote writes land whenever the mute switch is in auto
    wire key_mute_ok = !mute_ovr && (key_mute || key_start); // RULE16
    wire key_pwr_ok = !ext_low && auto_mute_sw && (key_high || key_low); // RULE18 RULE19
    wire rem_set = wr_ctrl && auto_mute_sw; // RULE19
    wire mute_nxt = rem_set ? s_axi_wdata[`CTRL_AUTO_MUTE] :
                    key_mute_ok ? key_mute : auto_mute_r;
    wire low_nxt = rem_set ? s_axi_wdata[`CTRL_AUTO_LOW] :
                   key_pwr_ok ? key_low : auto_low_r;
    wire set_change = ce && (mute_nxt != auto_mute_r || low_nxt != auto_low_r);
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            auto_mute_r <= 1'b0;
            auto_low_r <= 1'b0;
        end
        else if (ce)
        begin
            auto_mute_r <= mute_nxt;
            auto_low_r <= low_nxt;
        end
    end
    // Output priority per switch mode
    assign tx_mute = ilock ? 1'b1 :
                     !auto_mute_sw ? mute_sw == chg_pkg::MSW_MUTE : // RULE13
                     ext_mute ? 1'b1 : auto_mute_r; // RULE2 RULE15
    assign tx_low = link_low ? 1'b1 : // RULE20 RULE14
                    !auto_mute_sw ? 1'b0 :
                    ext_low ? 1'b1 : auto_low_r; // RULE17

    // Changeover state
    chg_pkg::chg_state_t state_r;
    logic sel_b_r;
    logic standby_act_r;
    logic [2:0] chg_cnt_r;
    logic [11:0] sec_cnt_r;
    wire pref_a = key_pref_a || rear_pref_a || rem_a;
    wire pref_b = key_pref_b || rear_pref_b || rem_b;
    wire pref_any = ce && (pref_a || pref_b);
    wire restart = pref_any || set_change || (ce && rem_clr); // RULE6 RULE12
    wire auto_sel = sel_sw == chg_pkg::SEL_AUTO;
    wire cur_failed = sel_b_r ? b_failed : a_failed;
    wire oth_failed = sel_b_r ? a_failed : b_failed;
    wire can_swap = !standby_act_r || !oth_failed; // RULE8
    wire do_swap = ce && auto_sel && state_r == chg_pkg::ST_WATCH && !restart
                   && cur_failed && can_swap;
    wire settle_done = sec_cnt_r >= 12'(`SETTLE_S - 1) && sec_tick;
    wire hour_done = sec_cnt_r >= 12'(`HOUR_S - 1) && sec_tick;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r <= chg_pkg::ST_SETTLE;
            sel_b_r <= 1'b0;
            standby_act_r <= 1'b0;
            chg_cnt_r <= 3'h0;
            sec_cnt_r <= 12'h000;
        end
        else if (ce)
        begin
            if (key_toggle || rem_tog) standby_act_r <= !standby_act_r; // RULE3
            if (restart)
            begin
                if (pref_a || pref_b) sel_b_r <= pref_b && !pref_a; // RULE4
                chg_cnt_r <= 3'h0;
                sec_cnt_r <= 12'h000;
                state_r <= chg_pkg::ST_SETTLE;
            end
            else if (do_swap)
            begin
                sel_b_r <= !sel_b_r; // RULE10
                chg_cnt_r <= chg_cnt_r + 3'h1; // RULE9
                sec_cnt_r <= 12'h000;
                state_r <= (chg_cnt_r + 3'h1 == `CHG_MAX) ? chg_pkg::ST_BLOCKED
                                                         : chg_pkg::ST_SETTLE;
            end
            else
            begin
                case (state_r)
                    chg_pkg::ST_SETTLE:
                    begin
                        if (settle_done) state_r <= chg_pkg::ST_WATCH;
                        else if (sec_tick) sec_cnt_r <= sec_cnt_r + 12'h001;
                    end
                    chg_pkg::ST_BLOCKED:
                    begin
                        // Hour timeout clears the counter and settles again
                        if (hour_done) // RULE11
                        begin
                            chg_cnt_r <= 3'h0;
                            sec_cnt_r <= 12'h000;
                            state_r <= chg_pkg::ST_SETTLE;
                        end
                        else if (sec_tick) sec_cnt_r <= sec_cnt_r + 12'h001;
                    end
                    chg_pkg::ST_WATCH: sec_cnt_r <= 12'h000;
                    default: state_r <= chg_pkg::ST_SETTLE;
                endcase
            end
        end
    end
    // Manual selector positions force the drive regardless of auto state
    assign drive_b_sel = auto_sel ? sel_b_r : sel_sw == chg_pkg::SEL_B; // RULE1
    assign standby_active = standby_act_r;

    // Status word: unknown health reported as code 2 while standby is passive
    wire [1:0] oth_health = !standby_act_r ? 2'h2 : {1'b0, oth_failed}; // RULE3
    wire [2:0] cnt_view = auto_sel ? chg_cnt_r : 3'h0; // RULE5
    wire [31:0] stat_word = {20'h00000, state_r, oth_health, cur_failed,
                             standby_act_r, sel_b_r, cnt_view, tx_low, tx_mute};
    wire [31:0] rd_word = s_axi_araddr == `CTRL_OFS ? {30'h0, auto_low_r, auto_mute_r} :
                          s_axi_araddr == `STAT_OFS ? stat_word : 32'h00000000;
    wire rd_ok = s_axi_araddr == `CTRL_OFS || s_axi_araddr == `STAT_OFS;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            bresp_r <= 2'h0;
            rresp_r <= 2'h0;
        end
        else if (ce)
        begin
            if (wr_go)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready) bvalid_r <= 1'b0;
            if (rd_go)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_ok ? 2'h0 : 2'h2;
            end
            else if (s_axi_rready) rvalid_r <= 1'b0;
        end
    end

    // Assertions
    sequence swap_seq;
        do_swap ##1 state_r != chg_pkg::ST_WATCH;
    endsequence
    a_swap_settles: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        do_swap |-> ##1 (state_r != chg_pkg::ST_WATCH))
        else $error("changeover did not start settle");
    a_pref_clears: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        pref_any |=> chg_cnt_r == 3'h0 && state_r == chg_pkg::ST_SETTLE)
        else $error("preference did not clear counter");
    a_set_clears: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        set_change |=> chg_cnt_r == 3'h0)
        else $error("setting change did not clear counter");
    a_count_cap: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        chg_cnt_r <= `CHG_MAX)
        else $error("counter above four");
    a_block_four: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        chg_cnt_r == `CHG_MAX |-> !do_swap)
        else $error("changeover after four");
    a_no_settle_swap: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        state_r == chg_pkg::ST_SETTLE |-> !do_swap)
        else $error("changeover during settle");
    a_ilock_mute: assert property (@(posedge clk) disable iff (!resetn) // RULE21
        !interlock_loop |-> tx_mute)
        else $error("open interlock not muting");
    a_link_low: assert property (@(posedge clk) disable iff (!resetn) // RULE20
        link_low |-> tx_low)
        else $error("link low not applied");
    a_manual_sel: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        sel_sw == chg_pkg::SEL_A |-> !drive_b_sel)
        else $error("manual A not forced");
    a_active_swap: assert property (@(posedge clk) disable iff (!resetn) // RULE8
        do_swap && standby_act_r |-> !oth_failed)
        else $error("swap to failed active drive");
    a_swap_flip: assert property (@(posedge clk) disable iff (!resetn) // RULE10
        swap_seq |-> sel_b_r != $past(sel_b_r, 2))
        else $error("swap did not flip drive");
    a_ext_mute: assert property (@(posedge clk) disable iff (!resetn) // RULE15
        mute_sw == chg_pkg::MSW_AUTO && ext_mute |-> tx_mute)
        else $error("external mute ignored");
endmodule

// [exciter_pair.sv]
// Purpose: model of the two exciter drives that report fast and slow fault status
// Assumes: mode 0 good, 1 fast fault, 2 slow fault, 3 both faults
// Notes: status lags the mode by one clock, as a real drive would
`timescale 1ns/1ps
module exciter_pair (
    input wire logic clk,
    input wire logic [1:0] a_mode,
    input wire logic [1:0] b_mode,
    output logic a_fast_bad,
    output logic a_slow_bad,
    output logic b_fast_bad,
    output logic b_slow_bad
);
    // Registered so a fault never lands in the time step that set it
    always_ff @(posedge clk)
    begin
        a_fast_bad <= a_mode[0];
        a_slow_bad <= a_mode[1];
        b_fast_bad <= b_mode[0];
        b_slow_bad <= b_mode[1];
    end
endmodule

// [tb.sv]
// Purpose: self-checking bench for changeover and mute/power control
// Assumes: tick shortened to 10 clocks, so one second is 10 cycles
// Notes: waits allow one tick of phase slack either way
`timescale 1ns/1ps
`include "chg_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
    logic clk, resetn, ce, ext_mute, ext_low, interlock_loop, link_low;
    chg_pkg::sel_sw_t sel_sw;
    chg_pkg::mute_sw_t mute_sw;
    logic [8:0] keys;
    logic [1:0] a_mode, b_mode, r, s_axi_bresp, s_axi_rresp;
    wire a_fast_bad, a_slow_bad, b_fast_bad, b_slow_bad;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic drive_b_sel, standby_active, tx_mute, tx_low;
    int mismatches, n_checks, m_b, m_mute, m_low, m_act, k;

    exciter_pair drives_u (.clk, .a_mode, .b_mode, .a_fast_bad, .a_slow_bad, .b_fast_bad,
        .b_slow_bad);
    changeover_ctrl #(.TICK_CYCLES(10)) dut_u (.clk, .resetn, .ce, .sel_sw, .mute_sw,
        .key_pref_a(keys[0]), .key_pref_b(keys[1]), .key_toggle(keys[2]), .key_mute(keys[3]),
        .key_start(keys[4]), .key_high(keys[5]), .key_low(keys[6]), .rear_pref_a(keys[7]),
        .rear_pref_b(keys[8]), .ext_mute, .ext_low, .interlock_loop, .link_low, .a_fast_bad,
        .a_slow_bad, .b_fast_bad, .b_slow_bad, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_b_sel, .standby_active, .tx_mute,
        .tx_low);

    // Ready is combinational on held inputs, so its value at the falling edge is what
    // the next rising edge samples
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb_;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb_ = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb_);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
    endtask
    // Status word against the model; st below zero skips the state field
    task automatic stat(int cnt, int st);
        rd(`STAT_OFS, d, r);
        `CHK("count", cnt, d[4:2])
        if (st >= 0) `CHK("state", st, d[11:10])
        `CHK("stat_sel", m_b, d[5])
        `CHK("standby", m_act, d[6])
        `CHK("sel_pin", m_b, drive_b_sel)
        `CHK("standby_pin", m_act, standby_active)
        `CHK("stat_rresp", 0, r)
    endtask
    task automatic press(int i);
        @(posedge clk);
        keys <= 9'h001 << i;
        @(posedge clk);
        keys <= 9'h000;
    endtask
    task automatic set_mode(int drv, int mode);
        @(posedge clk);
        if (drv == 0) a_mode <= mode[1:0];
        else b_mode <= mode[1:0];
    endtask
    // Faults the selected drive; no swap before mn cycles, a swap within mx more
    task automatic fail_cur(int mode, int mn, int mx);
        int n;
        set_mode(m_b, mode);
        repeat (mn) @(posedge clk);
        @(negedge clk);
        `CHK("early_sel", m_b, drive_b_sel)
        n = 0;
        while (drive_b_sel === m_b[0] && n < mx)
        begin
            @(negedge clk);
            n++;
        end
        m_b = 1 - m_b;
        `CHK("swap_sel", m_b, drive_b_sel)
        set_mode(1 - m_b, 0);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog sized for the hour wait plus every settle period
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize();
    end
    // Main sequence
    initial
    begin
        {resetn, keys, ext_mute, ext_low, link_low, a_mode, b_mode} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        interlock_loop = 1'b1;
        ce = 1'b1;
        sel_sw = chg_pkg::SEL_AUTO;
        mute_sw = chg_pkg::MSW_AUTO;
        {m_b, m_mute, m_low, m_act} = '0;
        void'($urandom(32'h9EC92B63));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        stat(0, 0);
        `CHK("passive_health", 2, d[9:8])
        rd(4'hC, d, r);
        `CHK("unmapped_rresp", 2, r)
        wr(4'hC, 32'h0000000F, r);
        `CHK("unmapped_bresp", 2, r)
        // Manual positions force a drive; a preference waits for auto
        @(posedge clk) sel_sw <= chg_pkg::SEL_B;
        @(negedge clk) `CHK("manual_b", 1, drive_b_sel)
        @(posedge clk) sel_sw <= chg_pkg::SEL_A;
        press(1);
        @(negedge clk) `CHK("manual_a", 0, drive_b_sel)
        @(posedge clk) sel_sw <= chg_pkg::SEL_AUTO;
        m_b = 1;
        stat(0, 0);
        wr(`CMD_OFS, 32'h00000001, r);
        m_b = 0;
        stat(0, 0);
        press(8);
        m_b = 1;
        stat(0, 0);
        press(7);
        m_b = 0;
        stat(0, 0);
        // Random mute and power requests against the priority model
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clk);
            mute_sw <= chg_pkg::mute_sw_t'($urandom_range(2));
            interlock_loop <= $urandom_range(3) != 0;
            ext_mute <= 1'($urandom_range(1));
            ext_low <= 1'($urandom_range(1));
            link_low <= $urandom_range(3) == 0;
            @(posedge clk);
            k = $urandom_range(4);
            if (k == 4)
            begin
                d = $urandom;
                wr(`CTRL_OFS, d, r);
                if (mute_sw == chg_pkg::MSW_AUTO)
                    {m_low, m_mute} = {31'h0, d[1], 31'h0, d[0]};
            end
            else
            begin
                // Mute keys still set the auto choice in manual mode; power keys need auto
                press(3 + k);
                if (k < 2 && interlock_loop && !ext_mute) m_mute = (k == 0);
                if (k > 1 && !ext_low && mute_sw == chg_pkg::MSW_AUTO)
                    m_low = (k == 3);
            end
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK("tx_mute", (!interlock_loop || mute_sw == chg_pkg::MSW_MUTE) ? 1 :
                (mute_sw == chg_pkg::MSW_START) ? 0 : ext_mute ? 1 : m_mute, tx_mute)
            `CHK("tx_low", link_low ? 1 : (mute_sw != chg_pkg::MSW_AUTO) ? 0 :
                ext_low ? 1 : m_low, tx_low)
            rd(`CTRL_OFS, d, r);
            `CHK("ctrl", {m_low[0], m_mute[0]}, d[1:0])
        end
        @(posedge clk);
        mute_sw <= chg_pkg::MSW_AUTO;
        {interlock_loop, ext_mute, ext_low, link_low} <= 4'h8;
        // Changeovers, settling, count limit and the hour release
        press(7);
        repeat (320) @(posedge clk);
        stat(0, 1);
        fail_cur(1, 9, 40);
        stat(1, 0);
        wr(`CTRL_OFS, {30'h0, m_low[0], !m_mute[0]}, r);
        m_mute = !m_mute;
        stat(0, 0);
        repeat (320) @(posedge clk);
        stat(0, 1);
        // Clock enable low freezes all state, so this preference must be lost
        ce <= 1'b0;
        press(7);
        ce <= 1'b1;
        stat(0, 1);
        fail_cur(2, 90, 130);
        wr(`CMD_OFS, 32'h00000008, r);
        stat(0, 0);
        for (int i = 1; i <= 4; i++)
        begin
            repeat (320) @(posedge clk);
            fail_cur(i[0] ? 1 : 2, i[0] ? 9 : 90, 130);
            stat(i, (i < 4) ? 0 : -1);
        end
        repeat (320) @(posedge clk);
        stat(4, 2);
        set_mode(m_b, 1);
        repeat (100) @(posedge clk);
        stat(4, 2);
        set_mode(m_b, 0);
        repeat (35000) @(posedge clk);
        stat(4, 2);
        repeat (700) @(posedge clk);
        stat(0, -1);
        // Active standby is taken only once it is healthy again
        press(2);
        m_act = 1;
        repeat (320) @(posedge clk);
        stat(0, 1);
        `CHK("active_health", 0, d[9:8])
        set_mode(1 - m_b, 1);
        repeat (40) @(posedge clk);
        stat(0, 1);
        `CHK("failed_health", 1, d[9:8])
        set_mode(m_b, 1);
        repeat (100) @(posedge clk);
        stat(0, -1);
        set_mode(1 - m_b, 0);
        fail_cur(1, 0, 60);
        summarize();
    end
endmodule
